//--- hw/spm_pkg.sv
package spm_pkg;
	localparam int CLK_PERIOD_NS = 50;
	localparam int SERVO_PERIOD_NS = 50000;
	localparam int SERVO_CYCLES = (SERVO_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DW = 12;
	localparam int AW = 4;
	localparam logic [3:0] ADR_MODE = 4'h1;
	localparam logic [3:0] ADR_STSEL = 4'h2;
	localparam logic [3:0] ADR_MSTAT = 4'h3;
	localparam logic [3:0] ADR_GAIN = 4'h4;
	localparam logic [3:0] ADR_XOVER = 4'h5;
	localparam logic [3:0] ADR_LIMIT = 4'h6;
	localparam logic [3:0] ADR_BRAKE = 4'he;
	localparam int MODE_AWU_BIT = 3;
	localparam int GAIN_F4_LSB = 3;
	localparam logic [9:0] SPD_TO_JUMP = 10'h2ee;
	localparam logic [9:0] SPD_STOP_HI = 10'h078;
	localparam logic [9:0] SPD_STOP_LO = 10'h03c;
	localparam logic signed [11:0] DRIVE_MAX = 12'sh7ff;
	localparam int P_SHIFT = 3;
	localparam int I_SHIFT = 8;
	localparam int IO_SHIFT = 4;
	localparam int LP_SHIFT = 10;

	typedef enum logic [2:0] {
		SPM_OFF, SPM_START1, SPM_START2, SPM_JUMP, SPM_JUMP1, SPM_PLAY, SPM_STOP1, SPM_STOP2
	} spm_mode_t;

	typedef struct packed {
		logic [2:0] gain_sel;
		logic [1:0] f4_sel;
		logic [1:0] f3_sel;
		logic [1:0] limit_sel;
		logic anti_windup;
		logic brake_low;
		logic [1:0] stsel;
	} spm_cfg_t;

	function automatic logic [8:0] spm_gain_x10(input logic [2:0] sel);
		logic [8:0] t [8] = '{9'h020, 9'h028, 9'h040, 9'h050, 9'h080, 9'h0a0, 9'h100, 9'h140};
		return t[sel];
	endfunction

	function automatic logic [8:0] spm_f4_centi(input logic [1:0] sel);
		logic [8:0] t [4] = '{9'h032, 9'h046, 9'h08c, 9'h118};
		return t[sel];
	endfunction

	function automatic logic [8:0] spm_f3_centi(input logic [1:0] sel);
		logic [8:0] t [4] = '{9'h055, 9'h0ab, 9'h156, 9'h156};
		return t[sel];
	endfunction

	function automatic logic [6:0] spm_limit_pct(input logic [1:0] sel);
		logic [6:0] t [4] = '{7'h64, 7'h4b, 7'h32, 7'h25};
		return t[sel];
	endfunction
endpackage

//--- hw/spm_tick.sv
`timescale 1ns/10ps
`default_nettype none
module spm_tick
	import spm_pkg::*;
#(
	parameter int PERIOD = SERVO_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	output logic tick
);
	typedef struct packed {
		logic [15:0] cnt;
		logic tick;
	} spm_tick_st_t;

	spm_tick_st_t st, next_st;

	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		if (st.cnt == 16'(PERIOD - 1)) begin
			next_st.cnt = 16'h0000;
			next_st.tick = 1'b1;
		end else begin
			next_st.cnt = st.cnt + 16'h0001;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tick = st.tick;
endmodule
`default_nettype wire

//--- hw/spm_loop.sv
`timescale 1ns/10ps
`default_nettype none
module spm_loop
	import spm_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic tick,
	input wire logic signed [11:0] err,
	input wire logic [2:0] gain_sel,
	input wire logic [1:0] f4_sel,
	input wire logic [1:0] f3_sel,
	input wire logic [2:0] overspeed,
	input wire logic integ_hold,
	input wire logic integ_clear,
	input wire logic anti_windup,
	output logic signed [11:0] drive,
	output logic sat
);
	typedef struct packed {
		logic signed [23:0] integ;
		logic signed [23:0] lp;
		logic signed [11:0] drive;
		logic sat;
	} spm_loop_st_t;

	spm_loop_st_t st, next_st;

	always_comb begin
		logic signed [31:0] p;
		logic signed [31:0] inc;
		logic signed [31:0] u;
		logic signed [31:0] lpn;
		p = '0;
		inc = '0;
		u = '0;
		lpn = '0;
		next_st = st;
		if (tick) begin
			// Gain does not see the overspeed factor; both corner frequencies do.
			p = (32'(err) * $signed({23'h0, spm_gain_x10(gain_sel)})) >>> P_SHIFT;
			inc = (32'(err) * $signed({23'h0, spm_f4_centi(f4_sel)}) * $signed({29'h0, overspeed})) >>> I_SHIFT;
			if (integ_clear) begin
				next_st.integ = '0;
			end else if (!integ_hold && !(anti_windup && st.sat)) begin
				next_st.integ = st.integ + 24'(inc);
			end
			u = p + (32'(st.integ) >>> IO_SHIFT);
			lpn = 32'(st.lp) + (((u - 32'(st.lp)) * $signed({23'h0, spm_f3_centi(f3_sel)})
				* $signed({29'h0, overspeed})) >>> LP_SHIFT);
			next_st.lp = 24'(lpn);
			if (lpn > 32'(DRIVE_MAX)) begin
				next_st.drive = DRIVE_MAX;
				next_st.sat = 1'b1;
			end else if (lpn < -32'(DRIVE_MAX)) begin
				next_st.drive = -DRIVE_MAX;
				next_st.sat = 1'b1;
			end else begin
				next_st.drive = 12'(lpn);
				next_st.sat = 1'b0;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign drive = st.drive;
	assign sat = st.sat;
endmodule
`default_nettype wire

//--- hw/spm_servo.sv
// Notes on behaviour
// - Loop gain and both crossover frequencies are set through two control registers.
// - Loop gain offers eight values, 3.2 up to 32.
// - Upper crossover selectable among 0.5, 0.7, 1.4, 2.8 Hz times overspeed.
// - Lower crossover selectable among 0.85, 1.71, 3.42 Hz times overspeed.
// - Crossovers scale with overspeed factor; gain does not.
// - FIFO overflow in play resets FIFO to half full; interpolator conceals loss.
// - Start 1 drives fixed positive level, holds PLL in reset, no speed data.
// - Start 2 accelerates with PLL tracking, moves to jump at 75% speed.
// - In start 2 the selected motor status readout is valid.
// - Jump enables servo, holds FIFO reset at half full, holds integrator.
// - Jump mutes audio but subcode stays readable; data discs stay unmuted.
// - Alternate jump behaves like jump with integrator kept at zero.
// - Entering play resets FIFO to half, then releases FIFO and mute.
// - Stop 1 drives fixed negative level to brake, no speed decision.
// - Stop 2 brakes with PLL tracking, ends at 12% or 6% speed.
// - At brake threshold the stopped flag rises and servo goes to off.
// - Operating mode is written through one control register, shared with the anti-windup bit.
// - Fixed start and stop drive limited to 100, 75, 50 or 37 percent.
// - With anti-windup on, integrator stops while output is saturated.
`timescale 1ns/10ps
`default_nettype none
module spm_servo
	import spm_pkg::*;
#(
	parameter int SERVO_PERIOD = SERVO_CYCLES
) (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic [AW-1:0] ADDR,
	input wire logic [DW-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [DW-1:0] RDATA,
	input wire logic [9:0] SPEED,
	input wire logic signed [11:0] FIFO_ERR,
	input wire logic FIFO_OVF,
	input wire logic [2:0] OVERSPEED,
	input wire logic DATA_DISC,
	output logic signed [11:0] MOTOR_DRIVE,
	output logic MOTOR_EN,
	output logic PLL_RST,
	output logic FIFO_RST,
	output logic AUDIO_MUTE,
	output logic MOTOR_STOPPED
);
	typedef struct packed {
		spm_mode_t mode;
		spm_mode_t pend_mode;
		logic pend;
		spm_cfg_t cfg;
		logic motor_stopped_flag;
		logic fifo_rst;
		logic mute;
		logic settle;
		logic ovf_pend;
		logic [DW-1:0] rdata;
		logic signed [11:0] drive;
	} spm_st_t;

	spm_st_t st, next_st;
	logic tick;
	logic signed [11:0] loop_drive;
	logic loop_sat;
	logic integ_hold;
	logic integ_clear;

	spm_tick #(
		.PERIOD(SERVO_PERIOD)
	) u_tick (
		.clk(CLK_SYS),
		.rst(RST),
		.tick(tick)
	);

	// Integrator is frozen in jump and pinned to zero in the long-jump variant.
	assign integ_hold = (st.mode != SPM_PLAY);
	assign integ_clear = (st.mode == SPM_JUMP1) || (st.mode == SPM_OFF) || (st.mode == SPM_START1)
		|| (st.mode == SPM_START2) || (st.mode == SPM_STOP1) || (st.mode == SPM_STOP2);

	spm_loop u_loop (
		.clk(CLK_SYS),
		.rst(RST),
		.tick(tick),
		.err(FIFO_ERR),
		.gain_sel(st.cfg.gain_sel),
		.f4_sel(st.cfg.f4_sel),
		.f3_sel(st.cfg.f3_sel),
		.overspeed(OVERSPEED),
		.integ_hold(integ_hold),
		.integ_clear(integ_clear),
		.anti_windup(st.cfg.anti_windup),
		.drive(loop_drive),
		.sat(loop_sat)
	);

	function automatic logic signed [11:0] fixed_level(input logic [1:0] sel);
		logic [18:0] prod;
		prod = 19'(DRIVE_MAX) * 19'(spm_limit_pct(sel));
		return 12'(prod / 19'h00064);
	endfunction

	function automatic logic speed_valid(input spm_mode_t m);
		return (m != SPM_START1) && (m != SPM_STOP1) && (m != SPM_OFF);
	endfunction

	always_comb begin
		spm_mode_t m;
		logic [9:0] stop_thr;
		m = st.mode;
		stop_thr = st.cfg.brake_low ? SPD_STOP_LO : SPD_STOP_HI;
		next_st = st;
		next_st.rdata = '0;

		// Register writes.
		if (WR) begin
			unique case (ADDR)
				ADR_MODE: begin
					next_st.pend_mode = spm_mode_t'(WDATA[2:0]);
					next_st.pend = 1'b1;
					next_st.cfg.anti_windup = WDATA[MODE_AWU_BIT];
					next_st.motor_stopped_flag = 1'b0;
				end
				ADR_STSEL: begin
					next_st.cfg.stsel = WDATA[1:0];
				end
				ADR_GAIN: begin
					next_st.cfg.gain_sel = WDATA[2:0];
					next_st.cfg.f4_sel = WDATA[GAIN_F4_LSB+1:GAIN_F4_LSB];
				end
				ADR_XOVER: begin
					next_st.cfg.f3_sel = WDATA[1:0];
				end
				ADR_LIMIT: begin
					next_st.cfg.limit_sel = WDATA[1:0];
				end
				ADR_BRAKE: begin
					next_st.cfg.brake_low = WDATA[0];
				end
				default: begin
				end
			endcase
		end

		// Register reads; data stand in the following cycle only.
		if (RD) begin
			unique case (ADDR)
				ADR_MODE: begin
					next_st.rdata = DW'({st.cfg.anti_windup, st.mode});
				end
				ADR_STSEL: begin
					next_st.rdata = DW'(st.cfg.stsel);
				end
				ADR_MSTAT: begin
					// Status is meaningless while the PLL is not tracking the disc.
					if (speed_valid(st.mode)) begin
						unique case (st.cfg.stsel)
							2'h0: next_st.rdata = DW'(SPEED);
							2'h1: next_st.rdata = DW'({st.pend, loop_sat, st.motor_stopped_flag});
							2'h2: next_st.rdata = DW'(st.drive);
							default: next_st.rdata = DW'(st.mode);
						endcase
					end else begin
						next_st.rdata = DW'({loop_sat, st.motor_stopped_flag}) & 12'h001;
					end
				end
				ADR_GAIN: begin
					next_st.rdata = DW'({st.cfg.f4_sel, st.cfg.gain_sel});
				end
				ADR_XOVER: begin
					next_st.rdata = DW'(st.cfg.f3_sel);
				end
				ADR_LIMIT: begin
					next_st.rdata = DW'(st.cfg.limit_sel);
				end
				ADR_BRAKE: begin
					next_st.rdata = DW'(st.cfg.brake_low);
				end
				default: begin
					next_st.rdata = '0;
				end
			endcase
		end

		// An overflow is caught at once and served at the next update.
		if (FIFO_OVF && st.mode == SPM_PLAY) begin
			next_st.ovf_pend = 1'b1;
		end

		if (tick) begin
			// Pending mode written by software is applied here, never mid-period.
			if (st.pend && !(WR && ADDR == ADR_MODE)) begin
				m = st.pend_mode;
				next_st.pend = 1'b0;
			end
			// An overflow that lands on the update itself stays pending for the next one.
			next_st.ovf_pend = FIFO_OVF && (st.mode == SPM_PLAY);
			if (m == SPM_START2 && SPEED >= SPD_TO_JUMP) begin
				m = SPM_JUMP;
			end
			if (m == SPM_STOP2 && SPEED <= stop_thr) begin
				m = SPM_OFF;
				next_st.motor_stopped_flag = 1'b1;
			end
			next_st.mode = m;
			unique case (m)
				SPM_PLAY: begin
					if (st.mode != SPM_PLAY) begin
						next_st.fifo_rst = 1'b1;
						next_st.mute = 1'b1;
						next_st.settle = 1'b1;
					end else if (st.ovf_pend) begin
						// Mute is left open so the interpolator can hide the gap.
						next_st.fifo_rst = 1'b1;
						next_st.settle = 1'b1;
					end else if (st.settle) begin
						next_st.fifo_rst = 1'b0;
						next_st.mute = 1'b0;
						next_st.settle = 1'b0;
					end
				end
				SPM_JUMP, SPM_JUMP1: begin
					next_st.fifo_rst = 1'b1;
					next_st.mute = 1'b1;
					next_st.settle = 1'b0;
				end
				default: begin
					next_st.fifo_rst = 1'b1;
					next_st.mute = 1'b1;
					next_st.settle = 1'b0;
				end
			endcase
			unique case (m)
				SPM_START1, SPM_START2: next_st.drive = fixed_level(st.cfg.limit_sel);
				SPM_STOP1, SPM_STOP2: next_st.drive = -fixed_level(st.cfg.limit_sel);
				SPM_JUMP, SPM_JUMP1, SPM_PLAY: next_st.drive = loop_drive;
				SPM_OFF: next_st.drive = '0;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			st <= '0;
			st.mode <= SPM_OFF;
			st.pend_mode <= SPM_OFF;
			st.fifo_rst <= 1'b1;
			st.mute <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign RDATA = st.rdata;
	assign MOTOR_DRIVE = st.drive;
	assign MOTOR_EN = (st.mode != SPM_OFF);
	assign PLL_RST = (st.mode == SPM_START1);
	assign FIFO_RST = st.fifo_rst;
	// Data discs keep serial and digital audio live; subcode path is never muted here.
	assign AUDIO_MUTE = st.mute && !DATA_DISC;
	assign MOTOR_STOPPED = st.motor_stopped_flag;
endmodule
`default_nettype wire

//--- dv/spm_servo_chk.sv
`timescale 1ns/10ps
`default_nettype none
module spm_servo_chk
	import spm_pkg::*;
#(
	parameter int SERVO_PERIOD = SERVO_CYCLES
) (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic [AW-1:0] ADDR,
	input wire logic WR,
	input wire logic RD,
	input wire logic [DW-1:0] RDATA,
	input wire logic [9:0] SPEED,
	input wire logic DATA_DISC,
	input wire logic signed [11:0] MOTOR_DRIVE,
	input wire logic MOTOR_EN,
	input wire logic PLL_RST,
	input wire logic AUDIO_MUTE,
	input wire logic MOTOR_STOPPED
);
	int quiet;
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (RST);
	sequence s_stop_rise;
		$rose(MOTOR_STOPPED);
	endsequence
	sequence s_flag_kept;
		MOTOR_STOPPED && !(WR && ADDR == ADR_MODE);
	endsequence
	// The drive may only move at servo updates, so a loop that runs every clock shows up here.
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			quiet <= 0;
		end else if ($changed(MOTOR_DRIVE)) begin
			quiet <= 0;
		end else if (quiet < SERVO_PERIOD) begin
			quiet <= quiet + 1;
		end
	end
	a_drive_at_tick: assert property ($changed(MOTOR_DRIVE) |-> quiet >= SERVO_PERIOD - 2)
		else $error("drive moved between updates");
	a_off_no_drive: assert property (!MOTOR_EN |-> MOTOR_DRIVE == 12'sh000)
		else $error("motor driven while off");
	a_start1_push: assert property (PLL_RST |-> MOTOR_EN && MOTOR_DRIVE > 12'sh000)
		else $error("start without positive drive");
	a_stop_to_off: assert property (s_stop_rise |-> !MOTOR_EN && MOTOR_DRIVE == 12'sh000)
		else $error("stopped flag without off");
	a_stop_speed: assert property (s_stop_rise |-> $past(SPEED) <= SPD_STOP_HI)
		else $error("stopped above threshold");
	a_flag_held: assert property (s_flag_kept |=> MOTOR_STOPPED)
		else $error("stopped flag dropped");
	a_data_unmuted: assert property (DATA_DISC && $past(DATA_DISC) |-> !AUDIO_MUTE)
		else $error("data disc muted");
	a_read_idle: assert property (!$past(RD) |-> RDATA == '0)
		else $error("read data outside answer");
endmodule
bind spm_servo spm_servo_chk #(.SERVO_PERIOD(SERVO_PERIOD)) u_chk (.CLK_SYS(CLK_SYS), .RST(RST),
	.ADDR(ADDR), .WR(WR), .RD(RD), .RDATA(RDATA), .SPEED(SPEED), .DATA_DISC(DATA_DISC),
	.MOTOR_DRIVE(MOTOR_DRIVE), .MOTOR_EN(MOTOR_EN), .PLL_RST(PLL_RST), .AUDIO_MUTE(AUDIO_MUTE),
	.MOTOR_STOPPED(MOTOR_STOPPED));
`default_nettype wire

//--- dv/spm_motor_model.sv
`timescale 1ns/10ps
`default_nettype none
module spm_motor_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic signed [11:0] drive,
	input wire logic pll_rst,
	output logic [9:0] speed,
	output logic signed [11:0] fifo_err
);
	logic signed [23:0] acc;
	logic flip;
	// Disc inertia: speed is the drive integrated over time, never below standstill.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			acc <= '0;
			flip <= 1'b0;
		end else begin
			flip <= !flip;
			if (acc + drive < 0) begin
				acc <= '0;
			end else if (acc + drive <= 24'sh1ff800) begin
				acc <= acc + drive;
			end
		end
	end
	// A PLL held in reset gives no speed, so the line toggles instead of holding a value.
	assign speed = pll_rst ? {5{flip, !flip}} : acc[20:11];
	// A slow disc gives a positive error, so the loop pushes it back towards nominal.
	assign fifo_err = 12'sd1000 - $signed({2'b00, acc[20:11]});
endmodule
`default_nettype wire

//--- dv/spm_servo_tb.sv
`timescale 1ns/10ps
`default_nettype none
module spm_servo_tb
	import spm_pkg::*;
;
	localparam int SP = 8;
	logic CLK_SYS, RST, WR, RD, FIFO_OVF, DATA_DISC, MOTOR_EN, PLL_RST, FIFO_RST, AUDIO_MUTE, MOTOR_STOPPED;
	logic [AW-1:0] ADDR;
	logic [DW-1:0] WDATA, RDATA, rv, wd;
	logic [9:0] SPEED;
	logic [2:0] OVERSPEED;
	logic signed [11:0] FIFO_ERR, MOTOR_DRIVE;
	int mismatches, compares, i;
	integer seed;
	int cyc = 0;
	spm_servo #(.SERVO_PERIOD(SP)) dut (.CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
		.RD(RD), .RDATA(RDATA), .SPEED(SPEED), .FIFO_ERR(FIFO_ERR), .FIFO_OVF(FIFO_OVF), .OVERSPEED(OVERSPEED),
		.DATA_DISC(DATA_DISC), .MOTOR_DRIVE(MOTOR_DRIVE), .MOTOR_EN(MOTOR_EN), .PLL_RST(PLL_RST),
		.FIFO_RST(FIFO_RST), .AUDIO_MUTE(AUDIO_MUTE), .MOTOR_STOPPED(MOTOR_STOPPED));
	spm_motor_model u_motor (.clk(CLK_SYS), .rst(RST), .drive(MOTOR_DRIVE), .pll_rst(PLL_RST),
		.speed(SPEED), .fifo_err(FIFO_ERR));
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
		compares = compares + 1;
		if (got !== exp) begin
			mismatches = mismatches + 1;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge CLK_SYS);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLK_SYS);
		WR <= 1'b0;
	endtask
	task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
		@(posedge CLK_SYS);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK_SYS);
		RD <= 1'b0;
		@(negedge CLK_SYS);
		d = RDATA;
	endtask
	task automatic ticks(input int n);
		repeat (n * SP) @(posedge CLK_SYS);
		@(negedge CLK_SYS);
	endtask
	function automatic logic [DW-1:0] lvl(input int sel);
		int pct[4] = '{100, 75, 50, 37};
		return DW'(2047 * pct[sel] / 100);
	endfunction
	initial begin
		CLK_SYS = 1'b0;
		forever #25 CLK_SYS = !CLK_SYS;
	end
	// A hang anywhere below lands here well after the slowest spin-up and brake.
	always @(posedge CLK_SYS) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			mismatches = mismatches + 1;
			end_of_test();
		end
	end
	initial begin
		seed = 97;
		mismatches = 0;
		compares = 0;
		RST = 1'b1;
		WR = 1'b0;
		RD = 1'b0;
		ADDR = '0;
		WDATA = '0;
		FIFO_OVF = 1'b0;
		DATA_DISC = 1'b0;
		OVERSPEED = 3'h1;
		repeat (3) @(posedge CLK_SYS);
		RST <= 1'b0;
		@(negedge CLK_SYS);
		chk(12'(FIFO_RST), 12'h001);
		chk(12'(MOTOR_EN), 12'h000);
		rd(4'h7, rv);
		chk(rv, 12'h000);
		for (i = 0; i < 8; i++) begin
			wd = (12'($random(seed)) & 12'hff8) | 12'(i);
			wr(ADR_GAIN, wd);
			OVERSPEED <= 3'($random(seed));
			rd(ADR_GAIN, rv);
			chk(rv, wd & 12'h01f);
			wr(ADR_XOVER, wd);
			rd(ADR_XOVER, rv);
			chk(rv, wd & 12'h003);
		end
		// A large overspeed makes the corner filter ring, so the spin-up below runs at factor one.
		OVERSPEED <= 3'h1;
		for (i = 0; i < 4; i++) begin
			wr(ADR_LIMIT, 12'(i));
			wr(ADR_MODE, 12'h001);
			ticks(2);
			chk(MOTOR_DRIVE, lvl(i));
			chk(12'(PLL_RST), 12'h001);
			wr(ADR_MODE, 12'h006);
			ticks(2);
			chk(MOTOR_DRIVE, -lvl(i));
		end
		rd(ADR_MODE, rv);
		chk(rv, 12'h006);
		wr(ADR_LIMIT, 12'h000);
		wr(ADR_STSEL, 12'h003);
		wr(ADR_MODE, 12'h002);
		rv = '0;
		for (i = 0; i < 2000 && rv !== 12'h003; i++) rd(ADR_MSTAT, rv);
		chk(rv, 12'h003);
		chk(12'(SPEED >= 10'd750), 12'h001);
		chk(12'(FIFO_RST), 12'h001);
		chk(12'(AUDIO_MUTE), 12'h001);
		@(posedge CLK_SYS);
		DATA_DISC <= 1'b1;
		ticks(0);
		@(negedge CLK_SYS);
		chk(12'(AUDIO_MUTE), 12'h000);
		@(posedge CLK_SYS);
		DATA_DISC <= 1'b0;
		wr(ADR_MODE, 12'h00d);
		ticks(2);
		chk(12'(FIFO_RST), 12'h000);
		chk(12'(AUDIO_MUTE), 12'h000);
		@(posedge CLK_SYS);
		FIFO_OVF <= 1'b1;
		@(posedge CLK_SYS);
		FIFO_OVF <= 1'b0;
		for (i = 0; i < 3 * SP && !FIFO_RST; i++) @(negedge CLK_SYS);
		chk(12'(FIFO_RST), 12'h001);
		chk(12'(AUDIO_MUTE), 12'h000);
		ticks(2);
		chk(12'(FIFO_RST), 12'h000);
		wr(ADR_MODE, 12'h004);
		ticks(2);
		chk(12'(FIFO_RST), 12'h001);
		chk(12'(AUDIO_MUTE), 12'h001);
		wr(ADR_BRAKE, 12'h001);
		wr(ADR_MODE, 12'h007);
		for (i = 0; i < 5000 && !MOTOR_STOPPED; i++) @(negedge CLK_SYS);
		chk(12'(SPEED <= 10'd60), 12'h001);
		chk(12'(MOTOR_EN), 12'h000);
		wr(ADR_STSEL, 12'h001);
		rd(ADR_MSTAT, rv);
		chk(rv & 12'h001, 12'h001);
		wr(ADR_MODE, 12'h000);
		@(negedge CLK_SYS);
		chk(12'(MOTOR_STOPPED), 12'h000);
		end_of_test();
	end
endmodule
`default_nettype wire
